// ==== logic/tkv_cmd_handler.sv ====
// Command handler: key store, value increment and decrement, field switch
//
// Function
// - Store-key opcode 0x8C; first argument is key sector, valid 0x00 to 0x0F.
// - Second argument picks key kind: 0xAA first kind, 0xBB second kind.
// - Six key bytes follow, most significant byte first.
// - Sixteen sectors each keep two keys; writing one kind spares the other.
// - Stored keys can never be read back by the host.
// - Store-key reply: length 0x02, opcode, status 0x4C success or 0x4E failure.
// - Increment opcode 0x8D, block byte, four-byte amount least significant first.
// - Increment fails unless block authenticated and incrementing is permitted.
// - Increment success reply: length 0x06, opcode, block, new value LSB first.
// - Decrement opcode 0x8E, same layout; needs authentication and permission.
// - Decrement success reply: length 0x06, opcode, block, new value LSB first.
// - Value failure reply: opcode and error 0x4E, 0x46 or 0x49.
// - Field opcode 0x90; argument 0x00 turns field off, nonzero turns it on.
// - Field reply: length 0x02, opcode, status 0x00 off or 0x01 on.
// - Every reply echoes the command opcode unchanged.
`timescale 1ns/1ps
`default_nettype none
module tkv_cmd_handler #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire  logic        sys_clk_in,
	input  wire  logic        reset_n_in,
	// APB slave
	input  wire  logic        psel_in,
	input  wire  logic        penable_in,
	input  wire  logic        pwrite_in,
	input  wire  logic [ADDR_W-1:0] paddr_in,
	input  wire  logic [31:0] pwdata_in,
	output logic       [31:0] prdata_out,
	output logic              pready_out,
	output logic              pslverr_out,
	output logic              irq_out,
	// Command bytes, opcode first
	input  wire  logic [7:0]  cmd_byte_in,
	input  wire  logic        cmd_valid_in,
	output logic              cmd_ready_out,
	// Response bytes, length field first
	output logic       [7:0]  rsp_byte_out,
	output logic              rsp_valid_out,
	input  wire  logic        rsp_ready_in,
	// Value block engine on the card side
	output logic              val_req_out,
	output logic              val_dec_out,
	output logic       [7:0]  val_block_out,
	output logic       [31:0] val_amount_out,
	input  wire  logic        val_done_in,
	input  wire  logic        val_ok_in,
	input  wire  logic [7:0]  val_err_in,
	input  wire  logic [31:0] val_result_in,
	input  wire  logic        blk_authed_in,
	input  wire  logic        blk_inc_ok_in,
	input  wire  logic        blk_dec_ok_in,
	// Key lookup for the authentication engine
	input  wire  logic [3:0]  key_sector_in,
	input  wire  logic        key_second_in,
	output logic       [47:0] key_out,
	// Field switch
	output logic              field_on_out
);
	// The decoder compares twelve address bits, and the register map needs at least four
	if (ADDR_W < 4 || ADDR_W > 12) begin : g_addr_check
		$error("ADDR_W must be 4 to 12");
	end

	tkv_pkg::tkv_state_t state_reg;
	logic [7:0]  opcode_reg;
	logic [7:0]  param_reg [0:7];
	logic [2:0]  cnt_reg;
	logic [3:0]  need_reg;
	logic [7:0]  buf_reg [0:6];
	logic [2:0]  len_reg;
	logic [2:0]  idx_reg;
	logic        fail_reg;
	logic [47:0] key_mem [0:31];
	logic        ctrl_en_reg;
	logic [tkv_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [tkv_pkg::IRQ_W-1:0] irq_mask_reg;

	logic cmd_hs;
	logic last_param;
	logic known_op;
	logic key_args_ok;
	logic key_wr;
	logic val_permit;
	logic rsp_last;
	logic ev_bad;
	localparam int IRQ_W_L = tkv_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] ev_vec;
	logic [11:0] addr_w;
	logic apb_setup;
	logic apb_do;

	assign cmd_hs = cmd_valid_in && cmd_ready_out;
	assign last_param = (state_reg == tkv_pkg::ST_PARAM) && cmd_hs
		&& (({1'b0, cnt_reg} + 4'h1) == need_reg);
	assign known_op = (cmd_byte_in == tkv_pkg::OP_KEY) || (cmd_byte_in == tkv_pkg::OP_INC)
		|| (cmd_byte_in == tkv_pkg::OP_DEC) || (cmd_byte_in == tkv_pkg::OP_FIELD);
	// Out-of-range sector or unknown kind never touches the key store
	assign key_args_ok = (param_reg[0] <= tkv_pkg::SECTOR_MAX)
		&& ((param_reg[1] == tkv_pkg::KIND_FIRST) || (param_reg[1] == tkv_pkg::KIND_SECOND));
	assign key_wr = (state_reg == tkv_pkg::ST_EXEC) && (opcode_reg == tkv_pkg::OP_KEY) && key_args_ok;
	// Card engine is only asked when the block is open for this direction
	assign val_permit = blk_authed_in
		&& ((opcode_reg == tkv_pkg::OP_INC) ? blk_inc_ok_in : blk_dec_ok_in);
	assign rsp_last = (state_reg == tkv_pkg::ST_RESP) && rsp_valid_out && rsp_ready_in
		&& (idx_reg == len_reg - 3'h1);
	assign ev_bad = (state_reg == tkv_pkg::ST_IDLE) && cmd_hs && !known_op;
	assign ev_vec = {ev_bad, rsp_last && fail_reg, rsp_last};

	// Command sequencing and response assembly
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			state_reg <= tkv_pkg::ST_IDLE;
			opcode_reg <= 8'h00;
			cnt_reg <= 3'h0;
			need_reg <= 4'h0;
			len_reg <= 3'h0;
			idx_reg <= 3'h0;
			fail_reg <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_byte_out <= 8'h00;
			for (int i = 0; i < 8; i++) begin
				param_reg[i] <= 8'h00;
			end
			for (int i = 0; i < 7; i++) begin
				buf_reg[i] <= 8'h00;
			end
		end else begin
			case (state_reg)
				tkv_pkg::ST_IDLE: begin
					if (cmd_hs && known_op) begin
						opcode_reg <= cmd_byte_in;
						cnt_reg <= 3'h0;
						state_reg <= tkv_pkg::ST_PARAM;
						if (cmd_byte_in == tkv_pkg::OP_KEY) begin
							need_reg <= tkv_pkg::NPAR_KEY;
						end else if (cmd_byte_in == tkv_pkg::OP_FIELD) begin
							need_reg <= tkv_pkg::NPAR_FIELD;
						end else begin
							need_reg <= tkv_pkg::NPAR_VAL;
						end
					end
				end
				tkv_pkg::ST_PARAM: begin
					if (cmd_hs) begin
						param_reg[cnt_reg] <= cmd_byte_in;
						cnt_reg <= cnt_reg + 3'h1;
					end
					if (last_param) begin
						state_reg <= tkv_pkg::ST_EXEC;
					end
				end
				tkv_pkg::ST_EXEC: begin
					buf_reg[1] <= opcode_reg;
					idx_reg <= 3'h0;
					if (opcode_reg == tkv_pkg::OP_KEY) begin
						buf_reg[0] <= tkv_pkg::LEN_SHORT;
						buf_reg[2] <= key_args_ok ? tkv_pkg::STAT_OK : tkv_pkg::STAT_FAIL;
						len_reg <= tkv_pkg::NRSP_SHORT;
						fail_reg <= !key_args_ok;
						state_reg <= tkv_pkg::ST_RESP;
					end else if (opcode_reg == tkv_pkg::OP_FIELD) begin
						buf_reg[0] <= tkv_pkg::LEN_SHORT;
						buf_reg[2] <= {7'h00, param_reg[0] != tkv_pkg::FIELD_OFF};
						len_reg <= tkv_pkg::NRSP_SHORT;
						fail_reg <= 1'b0;
						state_reg <= tkv_pkg::ST_RESP;
					end else if (val_permit) begin
						state_reg <= tkv_pkg::ST_WAIT;
					end else begin
						buf_reg[0] <= tkv_pkg::LEN_VAL_FAIL;
						buf_reg[2] <= tkv_pkg::ERR_VERIFY;
						len_reg <= tkv_pkg::NRSP_SHORT;
						fail_reg <= 1'b1;
						state_reg <= tkv_pkg::ST_RESP;
					end
				end
				tkv_pkg::ST_WAIT: begin
					if (val_done_in) begin
						state_reg <= tkv_pkg::ST_RESP;
						fail_reg <= !val_ok_in;
						if (val_ok_in) begin
							buf_reg[0] <= tkv_pkg::LEN_VALUE;
							buf_reg[2] <= param_reg[0];
							buf_reg[3] <= val_result_in[7:0];
							buf_reg[4] <= val_result_in[15:8];
							buf_reg[5] <= val_result_in[23:16];
							buf_reg[6] <= val_result_in[31:24];
							len_reg <= tkv_pkg::NRSP_VALUE;
						end else begin
							buf_reg[0] <= tkv_pkg::LEN_VAL_FAIL;
							buf_reg[2] <= val_err_in;
							len_reg <= tkv_pkg::NRSP_SHORT;
						end
					end
				end
				tkv_pkg::ST_RESP: begin
					// One idle cycle on entry lets the buffer settle before the first byte
					if (!rsp_valid_out) begin
						rsp_valid_out <= 1'b1;
						rsp_byte_out <= buf_reg[idx_reg];
					end else if (rsp_ready_in) begin
						if (rsp_last) begin
							rsp_valid_out <= 1'b0;
							state_reg <= tkv_pkg::ST_IDLE;
						end else begin
							idx_reg <= idx_reg + 3'h1;
							rsp_byte_out <= buf_reg[3'(idx_reg + 3'h1)];
						end
					end
				end
				default: begin
					state_reg <= tkv_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Command intake stalls from the last argument until the reply is gone
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			cmd_ready_out <= 1'b0;
		end else begin
			cmd_ready_out <= ctrl_en_reg && ((state_reg == tkv_pkg::ST_IDLE)
				|| ((state_reg == tkv_pkg::ST_PARAM) && !last_param));
		end
	end

	// Request to the card engine; amount reassembled from LSB-first bytes
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			val_req_out <= 1'b0;
			val_dec_out <= 1'b0;
			val_block_out <= 8'h00;
			val_amount_out <= 32'h00000000;
		end else begin
			val_req_out <= (state_reg == tkv_pkg::ST_EXEC) && (opcode_reg != tkv_pkg::OP_KEY)
				&& (opcode_reg != tkv_pkg::OP_FIELD) && val_permit;
			if (state_reg == tkv_pkg::ST_EXEC) begin
				val_dec_out <= (opcode_reg == tkv_pkg::OP_DEC);
				val_block_out <= param_reg[0];
				val_amount_out <= {param_reg[4], param_reg[3], param_reg[2], param_reg[1]};
			end
		end
	end

	// Key store: slot index is sector and kind, so the other kind stays intact
	always_ff @(posedge sys_clk_in) begin
		if (key_wr) begin
			key_mem[{param_reg[0][3:0], param_reg[1] == tkv_pkg::KIND_SECOND}] <= {param_reg[2],
				param_reg[3], param_reg[4], param_reg[5], param_reg[6], param_reg[7]};
		end
	end

	// Keys leave only toward the authentication engine, never on the reply path
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			key_out <= 48'h000000000000;
		end else begin
			key_out <= key_mem[{key_sector_in, key_second_in}];
		end
	end

	// Field switch
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			field_on_out <= 1'b0;
		end else if ((state_reg == tkv_pkg::ST_EXEC) && (opcode_reg == tkv_pkg::OP_FIELD)) begin
			field_on_out <= (param_reg[0] != tkv_pkg::FIELD_OFF);
		end
	end

	// APB slave with one wait state so read data can come from a flop
	assign addr_w = 12'(paddr_in);
	assign apb_setup = psel_in && penable_in && !pready_out;
	assign apb_do = psel_in && penable_in && pready_out;

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h00000000;
		end else begin
			pready_out <= apb_setup;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h00000000;
			if (apb_setup) begin
				if (addr_w == tkv_pkg::OFF_CTRL) begin
					prdata_out <= {31'h00000000, ctrl_en_reg};
				end else if (addr_w == tkv_pkg::OFF_IRQ_STAT) begin
					prdata_out <= {29'h00000000, irq_stat_reg};
				end else if (addr_w == tkv_pkg::OFF_IRQ_MASK) begin
					prdata_out <= {29'h00000000, irq_mask_reg};
				end else if (addr_w == tkv_pkg::OFF_STATE) begin
					prdata_out <= {16'h0000, opcode_reg, 6'h00, state_reg != tkv_pkg::ST_IDLE, field_on_out};
				end else begin
					pslverr_out <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			ctrl_en_reg <= tkv_pkg::CTRL_EN_RST;
			irq_mask_reg <= tkv_pkg::IRQ_MASK_RST;
		end else if (apb_do && pwrite_in) begin
			if (addr_w == tkv_pkg::OFF_CTRL) begin
				ctrl_en_reg <= pwdata_in[0];
			end else if (addr_w == tkv_pkg::OFF_IRQ_MASK) begin
				irq_mask_reg <= pwdata_in[IRQ_W_L-1:0];
			end
		end
	end

	// Sticky events: a new event wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			irq_stat_reg <= '0;
		end else if (apb_do && pwrite_in && (addr_w == tkv_pkg::OFF_IRQ_STAT)) begin
			irq_stat_reg <= (irq_stat_reg & ~pwdata_in[IRQ_W_L-1:0]) | ev_vec;
		end else begin
			irq_stat_reg <= irq_stat_reg | ev_vec;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	AST_KEY_RANGE: assert property ((state_reg == tkv_pkg::ST_EXEC) && (opcode_reg == 8'h8C)
		&& (param_reg[0] > 8'h0F) |=> buf_reg[2] == 8'h4E && !$past(key_wr))
		else $error("out-of-range sector not refused");
	AST_KEY_KIND: assert property ((state_reg == tkv_pkg::ST_EXEC) && (opcode_reg == 8'h8C)
		&& (param_reg[1] != 8'hAA) && (param_reg[1] != 8'hBB) |=> buf_reg[2] == 8'h4E && !$past(key_wr))
		else $error("unknown key kind not refused");
	AST_KEY_STORE: assert property (key_wr ##1 1'b1 |->
		key_mem[{$past(param_reg[0][3:0]), $past(param_reg[1]) == 8'hBB}][47:40] == $past(param_reg[2]))
		else $error("key top byte not the first key byte");
	AST_KEY_REPLY: assert property ((state_reg == tkv_pkg::ST_EXEC) && (opcode_reg == 8'h8C) |=>
		buf_reg[0] == 8'h02 && (buf_reg[2] == 8'h4C) == $past(key_args_ok))
		else $error("store-key reply wrong");
	AST_VAL_GATE: assert property (val_req_out |-> $past(blk_authed_in))
		else $error("value request without authentication");
	AST_VAL_OK: assert property ((state_reg == tkv_pkg::ST_WAIT) && val_done_in && val_ok_in |=>
		len_reg == 3'h7 && buf_reg[0] == 8'h06 && buf_reg[3] == $past(val_result_in[7:0]))
		else $error("value success reply wrong");
	AST_FIELD: assert property ((state_reg == tkv_pkg::ST_EXEC) && (opcode_reg == 8'h90) |=>
		field_on_out == ($past(param_reg[0]) != 8'h00) && buf_reg[2] == {7'h00, field_on_out})
		else $error("field state or status wrong");
	AST_ECHO: assert property ((state_reg == tkv_pkg::ST_RESP) |-> buf_reg[1] == opcode_reg)
		else $error("reply does not echo opcode");
	AST_STALL: assert property (last_param |=> !cmd_ready_out [*2])
		else $error("command intake not stalled");
endmodule
`default_nettype wire

// ==== logic/tkv_pkg.sv ====
// Constants and types for the tag key, value and field command handler
package tkv_pkg;
	// Command codes, echoed unchanged in every response
	localparam logic [7:0] OP_KEY       = 8'h8C;
	localparam logic [7:0] OP_INC       = 8'h8D;
	localparam logic [7:0] OP_DEC       = 8'h8E;
	localparam logic [7:0] OP_FIELD     = 8'h90;
	// Store-key arguments
	localparam logic [7:0] SECTOR_MAX   = 8'h0F;
	localparam logic [7:0] KIND_FIRST   = 8'hAA;
	localparam logic [7:0] KIND_SECOND  = 8'hBB;
	// Response length fields and status codes
	localparam logic [7:0] LEN_SHORT    = 8'h02;
	localparam logic [7:0] LEN_VALUE    = 8'h06;
	localparam logic [7:0] LEN_VAL_FAIL = 8'h02;
	localparam logic [7:0] STAT_OK      = 8'h4C;
	localparam logic [7:0] STAT_FAIL    = 8'h4E;
	localparam logic [7:0] ERR_NO_TAG   = 8'h4E;
	localparam logic [7:0] ERR_VERIFY   = 8'h46;
	localparam logic [7:0] ERR_BAD_VAL  = 8'h49;
	localparam logic [7:0] FIELD_OFF    = 8'h00;
	// Parameter byte counts and response byte counts
	localparam logic [3:0] NPAR_KEY     = 4'h8;
	localparam logic [3:0] NPAR_VAL     = 4'h5;
	localparam logic [3:0] NPAR_FIELD   = 4'h1;
	localparam logic [2:0] NRSP_SHORT   = 3'h3;
	localparam logic [2:0] NRSP_VALUE   = 3'h7;
	// Register byte offsets
	localparam logic [11:0] OFF_CTRL     = 12'h000;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h004;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
	localparam logic [11:0] OFF_STATE    = 12'h00C;
	// Reset values and interrupt bit positions
	localparam logic        CTRL_EN_RST  = 1'b1;
	localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
	localparam int          IRQ_W        = 3;
	localparam int          IRQ_DONE     = 0;
	localparam int          IRQ_FAIL     = 1;
	localparam int          IRQ_BAD      = 2;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_PARAM = 3'b001,
		ST_EXEC  = 3'b010,
		ST_WAIT  = 3'b011,
		ST_RESP  = 3'b100
	} tkv_state_t;
endpackage

// ==== test/tkv_card_model.sv ====
// Card-side value engine model answering increment and decrement requests
`timescale 1ns/1ps
`default_nettype none
module tkv_card_model (
	// Clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	// Request from the handler
	input  wire logic        val_req_in,
	input  wire logic        val_dec_in,
	input  wire logic [7:0]  val_block_in,
	input  wire logic [31:0] val_amount_in,
	// Behaviour commanded by the bench
	input  wire logic        fail_in,
	input  wire logic [7:0]  err_in,
	input  wire logic        slow_in,
	// Answer
	output logic             val_done_out,
	output logic             val_ok_out,
	output logic [7:0]       val_err_out,
	output logic [31:0]      val_result_out,
	output logic [7:0]       req_count_out
);
	logic [31:0] vals [256];
	logic [31:0] res;
	logic [31:0] nv;
	logic [3:0]  wait_cnt;
	logic        busy;
	// Block and amount are held by the handler until done
	assign nv = val_dec_in ? vals[val_block_in] - val_amount_in : vals[val_block_in] + val_amount_in;
	always_ff @(posedge sys_clk_in) begin
		val_done_out <= 1'b0;
		if (!reset_n_in) begin
			busy <= 1'b0;
			req_count_out <= 8'h00;
			res <= 32'h0;
			foreach (vals[i]) vals[i] <= 32'h0;
		end else if (val_req_in) begin
			busy <= 1'b1;
			wait_cnt <= slow_in ? 4'h7 : 4'h0;
			req_count_out <= req_count_out + 8'h01;
		end else if (busy && wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else if (busy) begin
			busy <= 1'b0;
			val_done_out <= 1'b1;
			res <= nv;
			if (!fail_in) vals[val_block_in] <= nv;
		end
	end
	// Outside done the error and result lines show the inverted value, not the real one
	assign val_ok_out = val_done_out & ~fail_in;
	assign val_err_out = val_done_out ? err_in : ~err_in;
	assign val_result_out = val_done_out ? res : ~res;
endmodule
`default_nettype wire

// ==== test/test_tag_key_value_rf_cmd_handler.sv ====
// Self-checking bench for the command handler
`timescale 1ns/1ps
`default_nettype none
module test_tag_key_value_rf_cmd_handler;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, val_amount, val_result;
	logic        pready, pslverr, irq, er, cmd_ready, rsp_valid, rsp_ready = 1'b0;
	logic [7:0]  cmd_byte = 8'h00, rsp_byte, val_block, val_err, req_count, err_code = 8'h00;
	logic        cmd_valid = 1'b0, val_req, val_dec, val_done, val_ok, field_on;
	logic        authed = 1'b0, inc_ok = 1'b0, dec_ok = 1'b0, fail = 1'b0, slow = 1'b0;
	logic [3:0]  key_sector = 4'h0;
	logic        key_second = 1'b0;
	logic [47:0] key;
	logic [31:0] shadow [256];
	logic [47:0] keys [16][2];
	logic [7:0]  errs [3] = '{8'h4E, 8'h46, 8'h49};
	logic [7:0]  fargs [5] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h00};
	logic [7:0]  a;
	int          miscompares = 0;
	int          comparisons = 0;

	tkv_cmd_handler tkv_cmd_handler_i (.sys_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .irq_out(irq), .cmd_byte_in(cmd_byte), .cmd_valid_in(cmd_valid),
		.cmd_ready_out(cmd_ready), .rsp_byte_out(rsp_byte), .rsp_valid_out(rsp_valid), .rsp_ready_in(rsp_ready),
		.val_req_out(val_req), .val_dec_out(val_dec), .val_block_out(val_block), .val_amount_out(val_amount),
		.val_done_in(val_done), .val_ok_in(val_ok), .val_err_in(val_err), .val_result_in(val_result),
		.blk_authed_in(authed), .blk_inc_ok_in(inc_ok), .blk_dec_ok_in(dec_ok), .key_sector_in(key_sector),
		.key_second_in(key_second), .key_out(key), .field_on_out(field_on));
	tkv_card_model tkv_card_model_i (.sys_clk_in(clk), .reset_n_in(rst_n), .val_req_in(val_req),
		.val_dec_in(val_dec), .val_block_in(val_block), .val_amount_in(val_amount), .fail_in(fail),
		.err_in(err_code), .slow_in(slow), .val_done_out(val_done), .val_ok_out(val_ok), .val_err_out(val_err),
		.val_result_out(val_result), .req_count_out(req_count));

	always #12.5 clk = ~clk;

	task automatic report_and_stop();
		$display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic timed_out(input string what);
		miscompares++;
		$display("Error %s expected handshake seen none", what);
		report_and_stop();
	endtask
	// Each bus task starts just after a rising edge and leaves one idle cycle behind
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) timed_out("pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic send(input logic [7:0] b[$]);
		int n;
		foreach (b[i]) begin
			cmd_valid <= 1'b1;
			cmd_byte <= b[i];
			n = 0;
			do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 50);
			if (cmd_ready !== 1'b1) timed_out("cmd_ready");
		end
		cmd_valid <= 1'b0;
		@(posedge clk);
	endtask
	// Whole reply is drained before the next command goes out
	task automatic rx(input string what, input logic [7:0] e[$]);
		int n;
		foreach (e[i]) begin
			if ($urandom_range(1) == 0) begin
				rsp_ready <= 1'b0;
				@(posedge clk);
			end
			rsp_ready <= 1'b1;
			n = 0;
			do begin @(posedge clk); n++; end while (rsp_valid !== 1'b1 && n < 50);
			if (rsp_valid !== 1'b1) timed_out(what);
			check(what, rsp_byte, e[i]);
		end
		rsp_ready <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [47:0] rnd48();
		return {16'($urandom()), 32'($urandom())};
	endfunction
	task automatic store_key(input logic [7:0] sec, input logic [7:0] kind, input logic [47:0] k);
		logic good;
		good = sec <= 8'h0F && (kind == 8'hAA || kind == 8'hBB);
		send('{8'h8C, sec, kind, k[47:40], k[39:32], k[31:24], k[23:16], k[15:8], k[7:0]});
		rx("key reply", '{8'h02, 8'h8C, good ? 8'h4C : 8'h4E});
		if (good) keys[sec[3:0]][kind == 8'hBB] = k;
	endtask
	task automatic value_op(input logic dec, input logic [7:0] blk, input logic [31:0] amt,
		input logic au, input logic io, input logic dk, input logic f, input logic [7:0] e);
		logic [7:0]  op, cnt;
		logic [31:0] nv;
		logic        perm;
		op = dec ? 8'h8E : 8'h8D;
		perm = au && (dec ? dk : io);
		cnt = req_count;
		authed <= au;
		inc_ok <= io;
		dec_ok <= dk;
		fail <= f;
		err_code <= e;
		nv = dec ? shadow[blk] - amt : shadow[blk] + amt;
		send('{op, blk, amt[7:0], amt[15:8], amt[23:16], amt[31:24]});
		if (!perm) rx("value refused", '{8'h02, op, 8'h46});
		else if (f) rx("value error", '{8'h02, op, e});
		else rx("value reply", '{8'h06, op, blk, nv[7:0], nv[15:8], nv[23:16], nv[31:24]});
		if (perm && !f) shadow[blk] = nv;
		check("engine requests", req_count - cnt, {7'h00, perm});
	endtask

	initial begin
		void'($urandom(32'h31BD));
		foreach (shadow[i]) shadow[i] = 32'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check("field after reset", field_on, 1'b0);
		apb(1'b0, 12'h000, 32'h0);
		check("ctrl reset", rd, 32'h1);
		apb(1'b0, 12'h008, 32'h0);
		check("mask reset", rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped error", er, 1'b1);
		// Field switch; entry two is a random nonzero argument
		for (int i = 0; i < 5; i++) begin
			a = i == 2 ? 8'($urandom_range(255, 2)) : fargs[i];
			send('{8'h90, a});
			rx("field reply", '{8'h02, 8'h90, {7'h00, a != 8'h00}});
			check("field pin", field_on, a != 8'h00);
		end
		// Every slot written once, then random overwrites and bad arguments
		for (int s = 0; s < 16; s++) begin
			store_key(8'(s), 8'hAA, rnd48());
			store_key(8'(s), 8'hBB, rnd48());
		end
		repeat (6) store_key(8'($urandom_range(15)), $urandom_range(1) ? 8'hAA : 8'hBB, rnd48());
		store_key(8'h10, 8'hAA, rnd48());
		store_key(8'h03, 8'hCC, rnd48());
		for (int s = 0; s < 32; s++) begin
			key_sector <= 4'(s / 2);
			key_second <= s[0];
			repeat (2) @(posedge clk);
			check("stored key", key, keys[s / 2][s % 2]);
		end
		// Refusals, engine errors, then successes with a wrapping amount
		for (int i = 0; i < 16; i++) begin
			slow <= i[0];
			value_op(i[1], 8'($urandom_range(3)), i == 7 ? 32'hFFFFFFFF : $urandom(),
				i != 0, i != 1, i != 2, i >= 3 && i < 6, errs[i % 3]);
		end
		// Last latched opcode is the decrement of the final pass, field off, idle
		apb(1'b0, 12'h00C, 32'h0);
		check("state reg", rd, 32'h00008E00);
		// Intake disabled by the enable bit, then restored
		apb(1'b1, 12'h000, 32'h0);
		@(posedge clk);
		check("intake off", cmd_ready, 1'b0);
		apb(1'b1, 12'h000, 32'h1);
		// Sticky status, mask and write-one-to-clear
		send('{8'h55});
		apb(1'b0, 12'h004, 32'h0);
		check("status bits", rd[2:0], 3'h7);
		check("irq masked off", irq, 1'b0);
		apb(1'b1, 12'h008, 32'h1);
		// Interrupt flop follows the mask one edge after the write lands
		@(posedge clk);
		check("irq unmasked", irq, 1'b1);
		apb(1'b1, 12'h004, 32'h7);
		apb(1'b0, 12'h004, 32'h0);
		check("status cleared", rd[2:0], 3'h0);
		check("irq cleared", irq, 1'b0);
		report_and_stop();
	end
endmodule
`default_nettype wire
